//--- rtl/mdw_pkg.sv
package mdw_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_OVLD  = 8'h04;
  localparam logic [7:0] REG_TEMP  = 8'h08;
  localparam logic [7:0] REG_FUNC  = 8'h0C;
  localparam logic [7:0] REG_WSTAT = 8'h10;
  localparam logic [7:0] REG_ISTAT = 8'h14;
  localparam logic [7:0] REG_IMASK = 8'h18;
  localparam logic [7:0] REG_HCTL  = 8'h1C;
  localparam logic [7:0] REG_SPEED = 8'h20;
  localparam logic [7:0] REG_OMAP  = 8'h24;
  localparam logic [7:0] REG_HIST  = 8'h40;
  // control fields
  localparam int CTRL_SRC_LO  = 0;
  localparam int CTRL_LOCK    = 2;
  localparam int CTRL_VIEW_LO = 4;
  localparam int VIEW_W       = 3;
  // warning bits and history codes
  localparam int NUM_WARN = 3;
  localparam int W_HEAT   = 0;
  localparam int W_OVLD   = 1;
  localparam int W_OPERR  = 2;
  localparam logic [1:0] CODE_NONE  = 2'h0;
  localparam logic [1:0] CODE_HEAT  = 2'h1;
  localparam logic [1:0] CODE_OVLD  = 2'h2;
  localparam logic [1:0] CODE_OPERR = 2'h3;
  // run sources
  localparam logic [1:0] SRC_PANEL = 2'h0;
  localparam logic [1:0] SRC_EXT   = 2'h1;
  localparam logic [1:0] SRC_DIR   = 2'h2;
  // reset values
  localparam logic [1:0]  RST_SRC   = 2'h0;
  localparam logic [2:0]  VIEW_SPEED = 3'h0;
  localparam logic [11:0] RST_OVLD  = 12'hC00;
  localparam logic [11:0] RST_TEMP  = 12'hA00;
  localparam logic [1:0]  RST_FUNC  = 2'h3;
  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : mdw_pkg

//--- rtl/mdw_warn_gate.sv
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
// =============================================
// Notes on behaviour
// - current warnings and history are readable as the monitor view
// - any active warning condition turns the warning output on
// - warning output reaches no terminal until software maps one
// - overheat above threshold raises a warning; motor keeps running
// - load above overload level raises a warning; motor keeps running
// - assigning run function to an already-on input: warning, stop
// - history keeps nine warnings newest first, oldest dropped
// - a repeat of the newest recorded warning type is not recorded
// - clear-history command erases every history entry
// - history is volatile: empty after every reset
// - external modes run only when exactly one run input is on
// - panel mode ignores the external run inputs
// - external modes ignore the panel run switch
// - direction-by-inputs mode ignores the panel direction switch
// - active alarm keeps the motor stopped
// - setting lock rejects panel setting changes
// - start-up view is taken once after reset, while the view field still holds VIEW_SPEED
module mdw_warn_gate #(
  parameter int HIST_DEPTH = 9,
  parameter int NUM_TERM   = 4,
  parameter int VAL_W      = 12
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                forwardRunInput,
  input  wire logic                backwardRunInput,
  input  wire logic                panelRunSwitch,
  input  wire logic                panelDirSwitch,
  input  wire logic [VAL_W-1:0]    tempValue,
  input  wire logic [VAL_W-1:0]    loadValue,
  input  wire logic                alarmActive,
  input  wire logic                panelSpeedWe,
  input  wire logic [VAL_W-1:0]    panelSpeed,
  output logic                     warningOutput,
  output logic [NUM_TERM-1:0]      outTerminal,
  output logic                     motorRun,
  output logic                     motorReverse,
  output logic [mdw_pkg::VIEW_W-1:0] startView,
  output logic                     irq
);
  import mdw_pkg::*;

  localparam int CNT_W = $clog2(HIST_DEPTH + 1);

  generate
    if (HIST_DEPTH < 1 || HIST_DEPTH > 47 || VAL_W > 32 ||
        NUM_TERM < 1 || NUM_TERM > 32) begin : g_bad
      $error("mdw_warn_gate: parameter out of range");
    end
  endgenerate

  // =============================================
  // pin synchronisers
  logic [3:0] pinMeta_q;
  logic [3:0] pinSync_q;
  logic [3:0] pinRaw;
  assign pinRaw = {panelDirSwitch, panelRunSwitch,
                   backwardRunInput, forwardRunInput};

  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_sync
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pinMeta_q[gp] <= 1'b0;
          pinSync_q[gp] <= 1'b0;
        end else begin
          pinMeta_q[gp] <= pinRaw[gp];
          pinSync_q[gp] <= pinMeta_q[gp];
        end
      end
    end
  endgenerate

  wire fwdS      = pinSync_q[0];
  wire bwdS      = pinSync_q[1];
  wire panelRunS = pinSync_q[2];
  wire panelDirS = pinSync_q[3];

  // =============================================
  // bus slave: write path
  logic              awHave_q;
  logic              wHave_q;
  logic [7:0]        wAddr_q;
  logic [31:0]       wData_q;
  logic [3:0]        wStrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;

  assign s_axi_awready = !awHave_q;
  assign s_axi_wready  = !wHave_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  wire doWrite = awHave_q && wHave_q && !bvalid_q;
  wire [31:0] wMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}},
                       {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
  wire [31:0] wBits = wData_q & wMask;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [31:0] msk);
    merge = (old & ~msk) | (dat & msk);
  endfunction : merge

  wire wCtrl  = doWrite && wAddr_q == REG_CTRL;
  wire wOvld  = doWrite && wAddr_q == REG_OVLD;
  wire wTemp  = doWrite && wAddr_q == REG_TEMP;
  wire wFunc  = doWrite && wAddr_q == REG_FUNC;
  wire wIstat = doWrite && wAddr_q == REG_ISTAT;
  wire wImask = doWrite && wAddr_q == REG_IMASK;
  wire wHctl  = doWrite && wAddr_q == REG_HCTL;
  wire wSpeed = doWrite && wAddr_q == REG_SPEED;
  wire wOmap  = doWrite && wAddr_q == REG_OMAP;
  wire wRoHit = wAddr_q == REG_WSTAT ||
                (wAddr_q >= REG_HIST &&
                 wAddr_q < REG_HIST + 8'(4 * HIST_DEPTH));
  wire wHit   = wCtrl | wOvld | wTemp | wFunc | wIstat | wImask |
                wHctl | wSpeed | wOmap;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHave_q <= 1'b0;
      wHave_q  <= 1'b0;
      wAddr_q  <= 8'h00;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !awHave_q) begin
        awHave_q <= 1'b1;
        wAddr_q  <= {s_axi_awaddr[7:2], 2'b00};
      end else if (doWrite) begin
        awHave_q <= 1'b0;
      end
      if (s_axi_wvalid && !wHave_q) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (doWrite) begin
        wHave_q <= 1'b0;
      end
      if (doWrite) begin
        bvalid_q <= 1'b1;
        // read-only words take the write silently
        bresp_q  <= (wHit || wRoHit) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // =============================================
  // settings
  logic [31:0]         ctrl_q;
  logic [31:0]         ovld_q;
  logic [31:0]         temp_q;
  logic [31:0]         func_q;
  logic [31:0]         speed_q;
  logic [31:0]         omap_q;
  logic [NUM_WARN-1:0] imask_q;

  wire [1:0] runSrc = ctrl_q[CTRL_SRC_LO +: 2];
  wire       lockOn = ctrl_q[CTRL_LOCK];
  wire [VIEW_W-1:0] viewSel = ctrl_q[CTRL_VIEW_LO +: VIEW_W];
  wire panelWriteOk = panelSpeedWe && !lockOn;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q  <= 32'(RST_SRC) | (32'(VIEW_SPEED) << CTRL_VIEW_LO);
      ovld_q  <= 32'(RST_OVLD);
      temp_q  <= 32'(RST_TEMP);
      func_q  <= 32'(RST_FUNC);
      speed_q <= 32'h0000_0000;
      omap_q  <= 32'h0000_0000;
      imask_q <= '0;
    end else begin
      if (wCtrl)  ctrl_q  <= merge(ctrl_q, wData_q, wMask);
      if (wOvld)  ovld_q  <= merge(ovld_q, wData_q, wMask);
      if (wTemp)  temp_q  <= merge(temp_q, wData_q, wMask);
      if (wFunc)  func_q  <= merge(func_q, wData_q, wMask);
      if (wOmap)  omap_q  <= merge(omap_q, wData_q, wMask);
      if (wImask) imask_q <= wBits[NUM_WARN-1:0];
      if (wSpeed) begin
        speed_q <= merge(speed_q, wData_q, wMask);
      end else if (panelWriteOk) begin
        speed_q <= 32'(panelSpeed);
      end
    end
  end

  // =============================================
  // warning conditions
  logic opErr_q;
  wire [31:0] funcMerged = merge(func_q, wData_q, wMask);
  wire [1:0]  funcNew    = funcMerged[1:0];
  // a run function newly given to a terminal that is already on
  wire opErrSet = wFunc &&
      ((funcNew[0] && !func_q[0] && fwdS) ||
       (funcNew[1] && !func_q[1] && bwdS));
  wire heatCond = tempValue > temp_q[VAL_W-1:0];
  wire ovldCond = loadValue > ovld_q[VAL_W-1:0];
  wire [NUM_WARN-1:0] warnVec = {opErr_q, ovldCond, heatCond};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opErr_q <= 1'b0;
    end else if (opErrSet) begin
      opErr_q <= 1'b1;
    end else if (!fwdS && !bwdS) begin
      opErr_q <= 1'b0; // cleared once the terminals are released
    end
  end

  // =============================================
  // run gating
  wire fwdE = fwdS && func_q[0];
  wire bwdE = bwdS && func_q[1];
  wire extMode = runSrc == SRC_EXT || runSrc == SRC_DIR;
  wire extReq  = fwdE ^ bwdE;
  wire runReq  = extMode ? extReq
               : (runSrc == SRC_PANEL) && panelRunS;
  wire revReq  = (runSrc == SRC_DIR) ? bwdE
               : (runSrc == SRC_EXT) ? bwdE ^ panelDirS
               : panelDirS;
  // overheat and overload leave running alone
  wire runOk = runReq && !alarmActive && !opErr_q;

  logic              warnOut_q;
  logic [NUM_TERM-1:0] term_q;
  logic              run_q;
  logic              rev_q;
  logic [VIEW_W-1:0] view_q;
  logic              started_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      warnOut_q <= 1'b0;
      term_q    <= '0;
      run_q     <= 1'b0;
      rev_q     <= 1'b0;
      view_q    <= VIEW_SPEED;
      started_q <= 1'b0;
    end else begin
      warnOut_q <= |warnVec;
      term_q    <= omap_q[NUM_TERM-1:0] & {NUM_TERM{|warnVec}};
      run_q     <= runOk;
      rev_q     <= revReq;
      started_q <= 1'b1;
      if (!started_q) view_q <= viewSel;
    end
  end

  assign warningOutput = warnOut_q;
  assign outTerminal   = term_q;
  assign motorRun      = run_q;
  assign motorReverse  = rev_q;
  assign startView     = view_q;

  // =============================================
  // warning history and interrupt status
  logic [NUM_WARN-1:0] warnPrev_q;
  logic [NUM_WARN-1:0] istat_q;
  logic [1:0]          hist_q [HIST_DEPTH];
  logic [CNT_W-1:0]    histCnt_q;

  wire [NUM_WARN-1:0] warnRise = warnVec & ~warnPrev_q;
  // one entry per cycle; simultaneous rises keep the hottest type
  wire [1:0] newCode = warnRise[W_HEAT]  ? CODE_HEAT
                     : warnRise[W_OVLD]  ? CODE_OVLD
                     : warnRise[W_OPERR] ? CODE_OPERR
                     : CODE_NONE;
  wire histClr  = wHctl && wBits[0];
  wire histPush = newCode != CODE_NONE && !histClr &&
                  newCode != hist_q[0];

  genvar gh;
  generate
    for (gh = 0; gh < HIST_DEPTH; gh++) begin : g_hist
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          hist_q[gh] <= CODE_NONE;
        end else if (histClr) begin
          hist_q[gh] <= CODE_NONE;
        end else if (histPush) begin
          if (gh == 0) begin
            hist_q[gh] <= newCode;
          end else begin
            hist_q[gh] <= hist_q[gh > 0 ? gh - 1 : 0];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      warnPrev_q <= '0;
      istat_q    <= '0;
      histCnt_q  <= '0;
    end else begin
      warnPrev_q <= warnVec;
      // a new event wins over a same-cycle clear
      istat_q <= (istat_q & ~(wIstat ? wBits[NUM_WARN-1:0] : '0))
               | warnRise;
      if (histClr) begin
        histCnt_q <= '0;
      end else if (histPush && histCnt_q != CNT_W'(HIST_DEPTH)) begin
        histCnt_q <= histCnt_q + CNT_W'(1);
      end
    end
  end

  assign irq = |(istat_q & imask_q);

  // =============================================
  // bus slave: read path
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  wire [7:0] rAddr  = {s_axi_araddr[7:2], 2'b00};
  wire [7:0] rOff   = rAddr - REG_HIST;
  wire       rHist  = rAddr >= REG_HIST &&
                      rAddr < REG_HIST + 8'(4 * HIST_DEPTH);
  wire [5:0] rIdx   = rOff[7:2];
  wire [1:0] histRd = hist_q[rHist ? int'(rIdx) : 0];

  logic [31:0] rMux;
  logic        rHit;
  always_comb begin
    rHit = 1'b1;
    case (rAddr)
      REG_CTRL:  rMux = ctrl_q;
      REG_OVLD:  rMux = ovld_q;
      REG_TEMP:  rMux = temp_q;
      REG_FUNC:  rMux = func_q;
      REG_WSTAT: rMux = 32'(warnVec);
      REG_ISTAT: rMux = 32'(istat_q);
      REG_IMASK: rMux = 32'(imask_q);
      REG_HCTL:  rMux = 32'(histCnt_q);
      REG_SPEED: rMux = speed_q;
      REG_OMAP:  rMux = omap_q;
      default: begin
        rMux = rHist ? 32'(histRd) : 32'h0000_0000;
        rHit = rHist;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rMux;
      rresp_q  <= rHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // =============================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_warn_raise: assert property (
    |warnVec |=> warningOutput)
    else $error("warning output missed an active condition");
  chk_warn_drop: assert property (
    !(|warnVec) |=> !warningOutput)
    else $error("warning output stuck without a condition");
  chk_term_map: assert property (
    (omap_q[NUM_TERM-1:0] == '0) |=> outTerminal == '0)
    else $error("warning reached an unmapped terminal");
  chk_heat_runs: assert property (
    heatCond && runReq && !alarmActive && !opErr_q |=> motorRun)
    else $error("overheat stopped the motor");
  chk_both_on: assert property (
    extMode && fwdE && bwdE |=> !motorRun)
    else $error("motor ran with both run inputs on");
  chk_panel_ign: assert property (
    runSrc == SRC_PANEL && !panelRunS |=> !motorRun)
    else $error("panel mode ran from external inputs");
  chk_ext_ign: assert property (
    extMode && !fwdE && !bwdE |=> !motorRun)
    else $error("external mode ran from the panel switch");
  chk_dir_mode: assert property (
    runSrc == SRC_DIR |=> motorReverse == $past(bwdE))
    else $error("direction switch applied in input mode");
  chk_alarm_stop: assert property (
    alarmActive |=> !motorRun)
    else $error("motor ran during an alarm");
  chk_operr_stop: assert property (
    opErrSet |=> opErr_q ##1 !motorRun)
    else $error("operation error did not stop the motor");
  chk_hist_clear: assert property (
    histClr |=> histCnt_q == '0 && hist_q[0] == CODE_NONE)
    else $error("history not erased");
  chk_hist_dup: assert property (
    histPush |=> hist_q[0] != hist_q[1] || histCnt_q == CNT_W'(1))
    else $error("repeated warning recorded");
  chk_hist_cap: assert property (
    histCnt_q <= CNT_W'(HIST_DEPTH))
    else $error("history count above depth");
  chk_lock_hold: assert property (
    lockOn && panelSpeedWe && !wSpeed |=> $stable(speed_q))
    else $error("locked setting changed from the panel");

  cov_heat_warn: cover property (heatCond ##1 warningOutput);
  cov_hist_full: cover property (histCnt_q == CNT_W'(HIST_DEPTH));
  cov_ext_run:   cover property (extMode && extReq ##1 motorRun);
  cov_op_error:  cover property (opErrSet);

endmodule : mdw_warn_gate

//--- testbench/mdw_ctrl_model.sv
`timescale 1ns/100ps
// ==================================================
// controller model: drives the run inputs, watches the warning output
module mdw_ctrl_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic cmdFwd,
  input  wire logic cmdBwd,
  input  wire logic warnIn,
  output logic      fwdOut,
  output logic      bwdOut,
  output logic      warnSeen
);
  // outputs change only after an edge, like a scanned controller output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fwdOut   <= 1'b0;
      bwdOut   <= 1'b0;
      warnSeen <= 1'b0;
    end else begin
      fwdOut   <= cmdFwd;
      bwdOut   <= cmdBwd;
      warnSeen <= warnIn;
    end
  end
endmodule : mdw_ctrl_model

//--- testbench/tb_mdw_warn_gate.sv
`timescale 1ns/100ps
module tb_mdw_warn_gate;
  import mdw_pkg::*;
  logic        clk = 0, rst = 1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, awready, wready, bvalid, arready, rvalid;
  logic        cmdFwd = 0, cmdBwd = 0, forward_run_input, bwd, pRun = 0, pDir = 0;
  logic        alarm = 0, spdWe = 0, warn, run, backward_run_input, irq, seen;
  logic [11:0] temp = 12'h000, load = 12'h000, spd = 12'h000;
  logic [3:0]  term;
  logic [2:0]  view;
  int          n_fail = 0, check_count = 0, cyc = 0, i;

  always #2.5 clk = ~clk;

  mdw_warn_gate mdw_warn_gate_inst (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .forwardRunInput(forward_run_input), .backwardRunInput(bwd), .panelRunSwitch(pRun),
    .panelDirSwitch(pDir), .tempValue(temp), .loadValue(load),
    .alarmActive(alarm), .panelSpeedWe(spdWe), .panelSpeed(spd),
    .warningOutput(warn), .outTerminal(term), .motorRun(run),
    .motorReverse(backward_run_input), .startView(view), .irq(irq));

  mdw_ctrl_model mdw_ctrl_model_inst (
    .clk(clk), .rst(rst), .cmdFwd(cmdFwd), .cmdBwd(cmdBwd), .warnIn(warn),
    .fwdOut(forward_run_input), .bwdOut(bwd), .warnSeen(seen));

  // ==================================================
  // helpers
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk(bresp, RESP_OKAY, "write answer");
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e, string m);
    rd(a);
    chk(d, e, m);
  endtask : rc

  // sync takes two edges and the output one more; the model adds one
  task automatic pins(input logic f, b, pr, pd);
    @(posedge clk);
    cmdFwd <= f;
    cmdBwd <= b;
    pRun   <= pr;
    pDir   <= pd;
    repeat (6) @(posedge clk);
  endtask : pins

  task automatic pw(input logic heat);
    @(posedge clk);
    if (heat) temp <= RST_TEMP + 12'h001;
    else load <= RST_OVLD + 12'h001;
    repeat (3) @(posedge clk);
    temp <= RST_TEMP;
    load <= RST_OVLD;
    repeat (3) @(posedge clk);
  endtask : pw

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end

  // ==================================================
  // tests
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(view, VIEW_SPEED, "start view");
    rc(REG_OVLD, RST_OVLD, "ovld reset");
    rc(REG_TEMP, RST_TEMP, "temp reset");
    rc(REG_FUNC, RST_FUNC, "func reset");
    rc(REG_OMAP, 0, "omap reset");
    rc(REG_HCTL, 0, "history empty");
    rd(8'h30);
    chk(r, RESP_SLVERR, "unmapped answer");
    $display("test reset done");
    pins(0, 0, 0, 0);
    wr(REG_CTRL, 32'(SRC_EXT));
    pins(1, 0, 0, 1);
    chk(run, 1, "ext one input");
    chk(backward_run_input, 1, "ext reverse by panel");
    pins(1, 1, 0, 0);
    chk(run, 0, "ext both inputs");
    pins(0, 0, 1, 0);
    chk(run, 0, "ext panel switch");
    pins(0, 0, 0, 0);
    wr(REG_CTRL, 32'(SRC_PANEL));
    pins(1, 0, 0, 0);
    chk(run, 0, "panel ignores inputs");
    pins(0, 0, 1, 0);
    chk(run, 1, "panel switch runs");
    pins(0, 0, 0, 0);
    wr(REG_CTRL, 32'(SRC_DIR));
    pins(1, 0, 0, 1);
    chk(backward_run_input, 0, "dir ignores panel dir");
    pins(0, 1, 0, 0);
    chk(backward_run_input, 1, "dir backward");
    alarm <= 1'b1;
    repeat (4) @(posedge clk);
    chk(run, 0, "alarm stops");
    alarm <= 1'b0;
    repeat (4) @(posedge clk);
    chk(run, 1, "alarm gone");
    $display("test run gating done");
    wr(REG_HCTL, 1);
    wr(REG_IMASK, 7);
    wr(REG_ISTAT, 7);
    temp <= RST_TEMP + 12'h001;
    repeat (3) @(posedge clk);
    chk(warn, 1, "overheat warning");
    chk(run, 1, "overheat keeps run");
    chk(term, 0, "unmapped terminal");
    chk(irq, 1, "irq raised");
    rc(REG_WSTAT, 1, "monitor overheat");
    wr(REG_OMAP, 1);
    // the terminal register follows the map one edge after the write
    @(posedge clk);
    chk(term, 1, "mapped terminal");
    chk(seen, 1, "controller sees warning");
    temp <= RST_TEMP;
    repeat (3) @(posedge clk);
    chk(warn, 0, "warning drops");
    wr(REG_IMASK, 0);
    chk(irq, 0, "irq masked");
    wr(REG_IMASK, 7);
    chk(irq, 1, "irq unmasked");
    wr(REG_ISTAT, 1);
    chk(irq, 0, "irq cleared");
    load <= RST_OVLD + 12'h001;
    repeat (3) @(posedge clk);
    chk(run, 1, "overload keeps run");
    rc(REG_WSTAT, 2, "monitor overload");
    load <= RST_OVLD;
    repeat (3) @(posedge clk);
    $display("test warnings done");
    rc(REG_HCTL, 2, "two recorded");
    pw(1);
    pw(1);
    rc(REG_HCTL, 3, "repeat skipped");
    for (i = 0; i < 7; i++) pw(i % 2);
    rc(REG_HCTL, 9, "history full");
    rc(REG_HIST, 32'(CODE_OVLD), "newest entry");
    rc(REG_HIST + 8'h04, 32'(CODE_HEAT), "second entry");
    rc(REG_HIST + 8'h20, 32'(CODE_OVLD), "oldest kept");
    wr(REG_HCTL, 1);
    rc(REG_HCTL, 0, "history cleared");
    rc(REG_HIST, 32'(CODE_NONE), "entry cleared");
    $display("test history done");
    pins(0, 0, 0, 0);
    wr(REG_FUNC, 2);
    pins(1, 0, 0, 0);
    wr(REG_FUNC, 3);
    repeat (3) @(posedge clk);
    rc(REG_WSTAT, 4, "operation error");
    chk(run, 0, "operation error stops");
    chk(warn, 1, "operation error warns");
    pins(0, 0, 0, 0);
    rc(REG_WSTAT, 0, "operation error gone");
    $display("test operation error done");
    spd <= 12'h123;
    spdWe <= 1'b1;
    @(posedge clk);
    spdWe <= 1'b0;
    rc(REG_SPEED, 32'h123, "panel speed");
    wr(REG_CTRL, 32'(SRC_DIR) | (32'h1 << CTRL_LOCK));
    spd <= 12'h456;
    spdWe <= 1'b1;
    @(posedge clk);
    spdWe <= 1'b0;
    rc(REG_SPEED, 32'h123, "locked speed");
    $display("test lock done");
    rc(REG_HCTL, 1, "operation error recorded");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc(REG_HCTL, 0, "history lost on reset");
    rc(REG_OMAP, 0, "map lost on reset");
    $display("test second reset done");
    results();
  end
endmodule : tb_mdw_warn_gate
